// file: include/adc_seq_pkg.sv
// constants, field layouts and state types for the converter sequencer
// assumes a 32-bit apb master and one 100 mhz clock
package adc_seq_pkg;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_DLY = 5'h03;
    localparam logic [4:0] IDX_WIN = 5'h04;
    localparam logic [4:0] IDX_SAMP = 5'h05;
    localparam logic [4:0] IDX_MUX = 5'h06;
    localparam logic [4:0] IDX_CMD = 5'h08;
    localparam logic [4:0] IDX_EVT = 5'h09;
    localparam logic [4:0] IDX_IEN = 5'h0a;
    localparam logic [4:0] IDX_FLG = 5'h0b;
    localparam logic [4:0] IDX_DBG = 5'h0c;
    localparam logic [4:0] IDX_TMP = 5'h0d;
    localparam logic [4:0] IDX_RES_L = 5'h10;
    localparam logic [4:0] IDX_RES_H = 5'h11;
    localparam logic [4:0] IDX_WLO_L = 5'h12;
    localparam logic [4:0] IDX_WLO_H = 5'h13;
    localparam logic [4:0] IDX_WHI_L = 5'h14;
    localparam logic [4:0] IDX_WHI_H = 5'h15;
    // flag and enable bit positions
    localparam int FLG_RES = 0;
    localparam int FLG_WIN = 1;
    // timing: divider in system clocks, base lengths in converter clock ticks
    localparam logic [7:0] ADC_DIV = 8'h02;
    localparam logic [8:0] SAMP_BASE = 9'h002;
    localparam logic [8:0] SETTLE_BASE = 9'h010;
    localparam logic [2:0] SETTLE_MAX_CODE = 3'h5;
    localparam logic [2:0] ACC_MAX_CODE = 3'h6;
    // window comparator modes
    localparam logic [2:0] WM_BELOW = 3'h1;
    localparam logic [2:0] WM_ABOVE = 3'h2;
    localparam logic [2:0] WM_INSIDE = 3'h3;
    localparam logic [2:0] WM_OUTSIDE = 3'h4;

    typedef enum logic [2:0] {
        S_IDLE, S_SETTLE, S_SAMPLE, S_CONV, S_GAP
    } seq_st_t;

    // request lines toward the analog converter
    typedef struct packed {
        logic go;
        logic open;
        logic [4:0] mux;
    } ana_ctrl_t;

    typedef struct packed {
        logic en;
        logic cont;
        logic refint;
        logic [2:0] accsel;
        logic [7:0] dly;
        logic [2:0] wmode;
        logic [4:0] sample_extension;
        logic [4:0] muxsel;
        logic evt;
        logic [1:0] ie;
        logic [1:0] flags;
        logic run_while_halted;
        logic [7:0] temp;
        logic [15:0] wlo;
        logic [15:0] whi;
        logic [15:0] result;
        logic [15:0] acc;
        logic busy;
        logic settle_pend;
        seq_st_t st;
        logic [8:0] cnt;
        logic [6:0] nsmp;
        logic [7:0] div;
        logic tick;
        ana_ctrl_t ana;
        logic pready;
        logic pslverr;
        logic [7:0] rdata;
        logic irq_res;
        logic irq_win;
    } seq_state_t;

    // every register and flag resets to zero
    localparam seq_state_t SEQ_RESET = '0;
endpackage : adc_seq_pkg

// file: core/adc_sequencer_control.sv
// sequencer, register file and window comparator of a sar converter
// assumes an apb master, a synchronous analog core and one clock
//
// Register access over APB was chosen for this implementation.

// Operation
// - settling delay before first sample: 0,16,32,64,128,256 ticks by code
// - settling also after switching to internal reference or deep wake
// - dither adds one to inter-sample delay after each sample, wraps
// - inter-sample delay in ticks with sampling capacitor kept open
// - window mode: none, below, above, inside, outside; rest reserved
// - compare 16-bit outcome with 16-bit lower and upper limits
// - sample two ticks plus the sample extension field
// - input selection changed mid-conversion applies only afterwards
// - selector codes: pins 0-11, loopback, reference, temperature, ground
// - writing start bit begins a measurement, or first continuous one
// - start bit reads one while busy and clears when done
// - event input starts a conversion when event trigger is enabled
// - each interrupt forwarded only when its enable bit is set
// - at measurement end set window flag if outcome matches mode
// - window flag cleared by writing one or reading outcome
// - outcome ready flag set when a measurement finishes
// - outcome ready flag cleared by writing one or reading outcome
// - halted in break debug unless run while halted is set
// - one shared byte buffer for all 16-bit registers
// - continuous mode restarts at once after each completion
// - window applies to the accumulated total only
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic event_i,
    input wire logic dbg_halt_i,
    input wire logic deep_wake_i,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output ana_ctrl_t ana_o,
    output logic irq_result_o,
    output logic irq_window_o
);
    seq_state_t s_reg;
    seq_state_t s_next;

    logic [4:0] idx;
    logic hit;
    logic [7:0] rd;
    logic [7:0] wd;
    logic wr_done;
    logic rd_done;
    logic halted;
    logic tk;
    logic start_sw;
    logic launch;
    logic [1:0] clr;
    logic [1:0] set;
    logic [8:0] settle_cyc;
    logic [6:0] tot;
    logic [15:0] total;
    logic wr_dly;

    // window match on the finished total
    function automatic logic win_match(input logic [2:0] m,
                                       input logic [15:0] r,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
        case (m)
            WM_BELOW: win_match = r < lo;
            WM_ABOVE: win_match = r > hi;
            WM_INSIDE: win_match = (r > lo) && (r < hi);
            WM_OUTSIDE: win_match = (r < lo) || (r > hi);
            default: win_match = 1'b0;
        endcase
    endfunction : win_match

    // address decode; unaligned or out of range gets an error
    assign idx = paddr_i[6:2];
    always_comb begin
        hit = 1'b0;
        if (paddr_i[11:7] == 5'h00 && paddr_i[1:0] == 2'h0) begin
            case (idx)
                IDX_CTRL, IDX_DLY, IDX_WIN, IDX_SAMP, IDX_MUX, IDX_CMD,
                IDX_EVT, IDX_IEN, IDX_FLG, IDX_DBG, IDX_TMP, IDX_RES_L,
                IDX_RES_H, IDX_WLO_L, IDX_WLO_H, IDX_WHI_L,
                IDX_WHI_H: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end

    // read mux; high bytes of 16-bit registers come from the buffer
    always_comb begin
        case (idx)
            IDX_CTRL: rd = {1'b0, s_reg.accsel, 1'b0, s_reg.refint,
                            s_reg.cont, s_reg.en};
            IDX_DLY: rd = s_reg.dly;
            IDX_WIN: rd = {5'h00, s_reg.wmode};
            IDX_SAMP: rd = {3'h0, s_reg.sample_extension};
            IDX_MUX: rd = {3'h0, s_reg.muxsel};
            IDX_CMD: rd = {7'h00, s_reg.busy};
            IDX_EVT: rd = {7'h00, s_reg.evt};
            IDX_IEN: rd = {6'h00, s_reg.ie};
            IDX_FLG: rd = {6'h00, s_reg.flags};
            IDX_DBG: rd = {7'h00, s_reg.run_while_halted};
            IDX_RES_L: rd = s_reg.result[7:0];
            IDX_WLO_L: rd = s_reg.wlo[7:0];
            IDX_WHI_L: rd = s_reg.whi[7:0];
            IDX_TMP, IDX_RES_H, IDX_WLO_H, IDX_WHI_H: rd = s_reg.temp;
            default: rd = 8'h00;
        endcase
    end

    // settling length by code; reserved codes give no delay
    always_comb begin
        if (s_reg.dly[7:5] == 3'h0 || s_reg.dly[7:5] > SETTLE_MAX_CODE) begin
            settle_cyc = 9'h000;
        end else begin
            settle_cyc = SETTLE_BASE << (s_reg.dly[7:5] - 3'h1);
        end
        // samples per measurement; reserved code acts as no accumulation
        if (s_reg.accsel > ACC_MAX_CODE) begin
            tot = 7'h01;
        end else begin
            tot = 7'h01 << s_reg.accsel;
        end
    end

    // apb effects land on the completing edge, data was staged before it
    assign wr_done = psel_i && penable_i && s_reg.pready && pwrite_i && hit;
    assign rd_done = psel_i && penable_i && s_reg.pready && !pwrite_i && hit;
    assign wd = pwdata_i[7:0];
    assign wr_dly = wr_done && idx == IDX_DLY;
    assign halted = dbg_halt_i && !s_reg.run_while_halted;
    assign tk = s_reg.tick && !halted;
    assign total = s_reg.acc + {6'h00, conv_data_i};

    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.ana.go = 1'b0;
        start_sw = 1'b0;
        launch = 1'b0;
        clr = 2'h0;
        set = 2'h0;

        // apb slave: pready one cycle after access phase opens
        if (psel_i && penable_i && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.rdata = (pwrite_i || !hit) ? 8'h00 : rd;
            s_next.pslverr = !hit;
        end
        if (wr_done) begin
            case (idx)
                IDX_CTRL: begin
                    if (wd[0] && !s_reg.en) begin
                        s_next.settle_pend = 1'b1;
                    end
                    if (wd[2] && !s_reg.refint) begin
                        s_next.settle_pend = 1'b1;
                    end
                    s_next.en = wd[0];
                    s_next.cont = wd[1];
                    s_next.refint = wd[2];
                    s_next.accsel = wd[6:4];
                end
                IDX_DLY: s_next.dly = wd;
                IDX_WIN: s_next.wmode = wd[2:0];
                IDX_SAMP: s_next.sample_extension = wd[4:0];
                IDX_MUX: s_next.muxsel = wd[4:0];
                IDX_CMD: start_sw = wd[0];
                IDX_EVT: s_next.evt = wd[0];
                IDX_IEN: s_next.ie = wd[1:0];
                IDX_FLG: clr = wd[1:0];
                IDX_DBG: s_next.run_while_halted = wd[0];
                IDX_TMP, IDX_WLO_L, IDX_WHI_L: s_next.temp = wd;
                IDX_WLO_H: s_next.wlo = {wd, s_reg.temp};
                IDX_WHI_H: s_next.whi = {wd, s_reg.temp};
                default: ;
            endcase
        end
        if (rd_done) begin
            case (idx)
                IDX_RES_L: begin
                    s_next.temp = s_reg.result[15:8];
                    clr = 2'h3;
                end
                IDX_RES_H: clr = 2'h3;
                IDX_WLO_L: s_next.temp = s_reg.wlo[15:8];
                IDX_WHI_L: s_next.temp = s_reg.whi[15:8];
                default: ;
            endcase
        end
        if (deep_wake_i) begin
            s_next.settle_pend = 1'b1;
        end

        // converter clock enable from a free divider
        s_next.tick = s_reg.div == ADC_DIV - 8'h01;
        s_next.div = s_next.tick ? 8'h00 : s_reg.div + 8'h01;

        // sequencer; ticks stop while halted, the analog core may finish
        case (s_reg.st)
            S_IDLE: begin
                // events are ignored while halted
                launch = s_reg.en && (start_sw ||
                         (event_i && s_reg.evt && !halted));
            end
            S_SETTLE: begin
                if (tk) begin
                    if (s_reg.cnt <= 9'h001) begin
                        s_next.settle_pend = 1'b0;
                        s_next.st = S_SAMPLE;
                        s_next.cnt = SAMP_BASE + {4'h0, s_reg.sample_extension};
                    end else begin
                        s_next.cnt = s_reg.cnt - 9'h001;
                    end
                end
            end
            S_SAMPLE: begin
                if (tk) begin
                    if (s_reg.cnt <= 9'h001) begin
                        s_next.st = S_CONV;
                        s_next.ana.go = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt - 9'h001;
                    end
                end
            end
            S_CONV: begin
                if (conv_done_i) begin
                    if (s_reg.dly[4] && !wr_dly) begin
                        s_next.dly[3:0] = s_reg.dly[3:0] + 4'h1;
                    end
                    if (s_reg.nsmp + 7'h01 == tot) begin
                        s_next.result = total;
                        set[FLG_RES] = 1'b1;
                        set[FLG_WIN] = win_match(s_reg.wmode, total,
                            s_reg.wlo, s_reg.whi);
                        if (s_reg.cont) begin
                            launch = 1'b1;
                        end else begin
                            s_next.st = S_IDLE;
                            s_next.busy = 1'b0;
                        end
                    end else begin
                        s_next.acc = total;
                        s_next.nsmp = s_reg.nsmp + 7'h01;
                        if (s_reg.dly[3:0] == 4'h0) begin
                            s_next.st = S_SAMPLE;
                            s_next.cnt = SAMP_BASE + {4'h0, s_reg.sample_extension};
                        end else begin
                            s_next.st = S_GAP;
                            s_next.cnt = {5'h00, s_reg.dly[3:0]};
                        end
                    end
                end
            end
            S_GAP: begin
                if (tk) begin
                    if (s_reg.cnt <= 9'h001) begin
                        s_next.st = S_SAMPLE;
                        s_next.cnt = SAMP_BASE + {4'h0, s_reg.sample_extension};
                    end else begin
                        s_next.cnt = s_reg.cnt - 9'h001;
                    end
                end
            end
            default: s_next.st = S_IDLE;
        endcase

        // new measurement: input selection is taken only here
        if (launch) begin
            s_next.busy = 1'b1;
            s_next.acc = 16'h0000;
            s_next.nsmp = 7'h00;
            s_next.ana.mux = s_reg.muxsel;
            if (s_next.settle_pend && settle_cyc != 9'h000) begin
                s_next.st = S_SETTLE;
                s_next.cnt = settle_cyc;
            end else begin
                s_next.settle_pend = 1'b0;
                s_next.st = S_SAMPLE;
                s_next.cnt = SAMP_BASE + {4'h0, s_reg.sample_extension};
            end
        end
        // disabling drops any measurement in flight
        if (!s_reg.en) begin
            s_next.st = S_IDLE;
            s_next.busy = 1'b0;
        end

        // set wins over a clear in the same cycle
        s_next.flags = (s_reg.flags & ~clr) | set;
        // capacitor stays open while sampling and between samples
        s_next.ana.open = s_next.st == S_SAMPLE || s_next.st == S_GAP;
        s_next.irq_res = s_next.flags[FLG_RES] && s_next.ie[FLG_RES];
        s_next.irq_win = s_next.flags[FLG_WIN] && s_next.ie[FLG_WIN];
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s_reg <= SEQ_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o = {24'h000000, s_reg.rdata};
    assign pready_o = s_reg.pready;
    assign pslverr_o = s_reg.pslverr;
    assign ana_o = s_reg.ana;
    assign irq_result_o = s_reg.irq_res;
    assign irq_window_o = s_reg.irq_win;

    // helper: unhalted ticks spent in the sampling phase
    logic [8:0] samp_ticks;
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || s_reg.st != S_SAMPLE) begin
            samp_ticks <= 9'h000;
        end else if (tk) begin
            samp_ticks <= samp_ticks + 9'h001;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_w1c_res;
        wr_done && idx == IDX_FLG && wd[FLG_RES] && !set[FLG_RES];
    endsequence
    sequence s_last_sample;
        s_reg.st == S_CONV && conv_done_i && s_reg.nsmp + 7'h01 == tot;
    endsequence

    a_res_flag_cause: assert property (
        $rose(s_reg.flags[FLG_RES]) |-> $past(s_reg.st == S_CONV
            && conv_done_i && s_reg.nsmp + 7'h01 == tot))
        else $error("ready flag set without a finished measurement");
    a_win_mode_gate: assert property (
        $rose(s_reg.flags[FLG_WIN]) |-> $past(s_reg.wmode >= WM_BELOW
            && s_reg.wmode <= WM_OUTSIDE))
        else $error("window flag set under no or reserved mode");
    a_irq_enable_gate: assert property (
        irq_result_o |-> s_reg.ie[FLG_RES] && s_reg.flags[FLG_RES])
        else $error("result interrupt without enable");
    a_mux_held_busy: assert property (
        s_reg.st != S_IDLE && !launch |=> $stable(ana_o.mux))
        else $error("input changed during a measurement");
    a_sample_length: assert property (
        s_reg.st == S_CONV && $past(s_reg.st) == S_SAMPLE |->
            samp_ticks == SAMP_BASE + {4'h0, s_reg.sample_extension})
        else $error("sampling phase length wrong");
    a_dither_step: assert property (
        s_reg.st == S_CONV && conv_done_i && s_reg.dly[4] && !wr_dly
            |=> s_reg.dly[3:0] == $past(s_reg.dly[3:0]) + 4'h1)
        else $error("delay not stepped after sample");
    a_halt_freeze: assert property (
        halted && s_reg.en && (s_reg.st == S_SAMPLE || s_reg.st == S_GAP)
            |=> $stable(s_reg.cnt))
        else $error("sequencer ran while halted");
    a_w1c_res_clear: assert property (
        s_w1c_res |=> !s_reg.flags[FLG_RES])
        else $error("ready flag survived write one");
    a_busy_read_back: assert property (
        s_last_sample ##0 (!s_reg.cont && s_reg.en) |=> !s_reg.busy ##1
            !s_reg.busy || s_reg.st != S_IDLE)
        else $error("busy not cleared at completion");
endmodule : adc_sequencer_control

// file: sim/adc_sequencer_control_tb_top.sv
// self-checking bench for the converter sequencer and its register file
// assumes the design answers apb with one wait state and a 100 mhz clock
module adc_sequencer_control_tb_top
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic event_i = 1'b0;
    logic dbg_halt_i = 1'b0;
    logic deep_wake_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic [9:0] conv_data_i = 10'h2aa;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    ana_ctrl_t ana_o;
    logic irq_result_o;
    logic irq_window_o;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int t_open = 0;
    int open_run = 0;
    int open_len = 0;
    logic open_q = 1'b0;
    logic [15:0] sum_exp = 16'h0000;

    always #5 sys_clk_i = ~sys_clk_i;

    adc_sequencer_control adc_sequencer_control_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .event_i(event_i), .dbg_halt_i(dbg_halt_i),
        .deep_wake_i(deep_wake_i), .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i), .ana_o(ana_o),
        .irq_result_o(irq_result_o), .irq_window_o(irq_window_o)
    );

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
             output logic [7:0] rd, output logic err);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {5'h00, idx, 2'b00};
        pwdata_i <= {24'h000000, wd};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata_o[7:0];
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task wr(input logic [4:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task rd(input logic [4:0] idx, output logic [7:0] v);
        logic e;
        apb(1'b0, idx, 8'h00, v, e);
    endtask : rd

    // polls a register bit under a bounded count
    task wait_bit(input logic [4:0] idx, input int b, input logic val);
        logic [7:0] v;
        int n;
        n = 0;
        do begin
            rd(idx, v);
            n++;
        end while (v[b] !== val && n < 3000);
        check(v[b], val);
    endtask : wait_bit

    task pulse(input int k);
        @(posedge sys_clk_i);
        if (k == 0) event_i <= 1'b1;
        else deep_wake_i <= 1'b1;
        @(posedge sys_clk_i);
        event_i <= 1'b0;
        deep_wake_i <= 1'b0;
    endtask : pulse

    // one measurement by command; selector changed while it runs
    task conv(input logic [7:0] ctl, input logic [4:0] m0, m1,
              output int dly);
        logic [7:0] v;
        int t0;
        wr(IDX_MUX, {3'h0, m0});
        wr(IDX_CTRL, ctl);
        sum_exp = 16'h0000;
        wr(IDX_CMD, 8'h01);
        t0 = cyc;
        // busy read first: a short sample may end before a later read
        rd(IDX_CMD, v);
        check(v, 8'h01);
        wr(IDX_MUX, {3'h0, m1});
        check(ana_o.mux, m0);
        wait_bit(IDX_CMD, 0, 1'b0);
        dly = t_open - t0;
    endtask : conv

    function automatic logic win_f(logic [2:0] m, logic [15:0] r, lo, hi);
        case (m)
            WM_BELOW: return r < lo;
            WM_ABOVE: return r > hi;
            WM_INSIDE: return (r > lo) && (r < hi);
            WM_OUTSIDE: return (r < lo) || (r > hi);
            default: return 1'b0;
        endcase
    endfunction : win_f

    // far-side converter: answers each go after a random delay
    initial begin
        logic [9:0] d;
        forever begin
            @(posedge sys_clk_i);
            if (ana_o.go === 1'b1) begin
                repeat ($urandom_range(3, 1)) @(posedge sys_clk_i);
                d = 10'($urandom);
                conv_data_i <= d;
                conv_done_i <= 1'b1;
                sum_exp = sum_exp + 16'(d);
                @(posedge sys_clk_i);
                conv_done_i <= 1'b0;
                conv_data_i <= ~d;
            end
        end
    end

    // sampling-window timing monitor and hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        open_q <= ana_o.open;
        if (ana_o.open === 1'b1) begin
            open_run <= open_q ? open_run + 1 : 1;
            if (!open_q) t_open <= cyc;
        end
        if (ana_o.go === 1'b1) open_len <= open_run;
        if (cyc > 80000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        logic [4:0] ridx[10];
        logic [7:0] rmask[10];
        logic [7:0] v, d;
        logic e, w;
        logic [2:0] acc;
        logic [4:0] sl;
        logic [1:0] ien;
        logic [15:0] lo, hi;
        int d0, dd, t, c;
        ridx = '{IDX_DLY, IDX_WIN, IDX_SAMP, IDX_MUX, IDX_CMD, IDX_EVT,
                 IDX_IEN, IDX_FLG, IDX_DBG, IDX_TMP};
        rmask = '{8'hff, 8'h07, 8'h1f, 8'h1f, 8'h00, 8'h01, 8'h03, 8'h00,
                  8'h01, 8'hff};
        void'($urandom(32'h7ee1));
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        // reset values, field read-back, shared buffer, unmapped place
        for (int i = 0; i < 10; i++) begin
            rd(ridx[i], v);
            check(v, 8'h00);
            if (rmask[i] != 8'h00) begin
                d = 8'($urandom);
                wr(ridx[i], d);
                rd(ridx[i], v);
                check(v & rmask[i], d & rmask[i]);
                wr(ridx[i], 8'h00);
            end
        end
        apb(1'b1, 5'h07, 8'h5a, v, e);
        check(e, 1'b1);
        apb(1'b0, 5'h07, 8'h00, v, e);
        check({e, v}, 9'h100);
        $display("test registers done");
        // settling: baseline, then armed by reference switch and wake
        wr(IDX_SAMP, 8'h00);
        conv(8'h01, 5'h00, 5'h00, d0);
        for (int k = 1; k < 7; k++) begin
            wr(IDX_DLY, {3'(k), 5'h00});
            if (k > 1) pulse(1);
            conv(8'h05, 5'h00, 5'h00, dd);
            t = (k < 6) ? (16 << (k - 1)) : 0;
            check((dd - d0 >= 2 * t - 2) && (dd - d0 <= 2 * t + 2), 1);
        end
        wr(IDX_DLY, 8'h00);
        $display("test settling done");
        // window modes, flags, enables, accumulation, 16-bit pairs
        for (int i = 0; i < 16; i++) begin
            acc = 3'($urandom_range(2, 0));
            sl = 5'($urandom_range(31, 16));
            ien = 2'($urandom);
            lo = 16'($urandom_range(2000, 0));
            hi = 16'($urandom_range(3000, int'(lo)));
            c = $urandom_range(15, 0);
            wr(IDX_SAMP, {3'h0, sl});
            wr(IDX_WIN, {5'h00, 3'(i)});
            wr(IDX_IEN, {6'h00, ien});
            wr(IDX_WLO_L, lo[7:0]);
            wr(IDX_WLO_H, lo[15:8]);
            wr(IDX_WHI_L, hi[7:0]);
            wr(IDX_WHI_H, hi[15:8]);
            conv({1'b0, acc, 4'h1}, 5'(c < 12 ? c : c + 16), 5'(c), dd);
            if (acc == 3'h0) begin
                t = 2 * (2 + int'(sl));
                check((open_len >= t - 2) && (open_len <= t + 2), 1);
            end
            w = win_f(3'(i), sum_exp, lo, hi);
            rd(IDX_FLG, v);
            check(v, {6'h00, w, 1'b1});
            check({irq_window_o, irq_result_o}, {ien[1] & w, ien[0]});
            if (i % 2 == 1) begin
                wr(IDX_FLG, 8'h00);
                rd(IDX_FLG, v);
                check(v, {6'h00, w, 1'b1});
                wr(IDX_FLG, 8'h03);
                rd(IDX_FLG, v);
                check(v, 8'h00);
            end
            rd(IDX_RES_L, v);
            check(v, sum_exp[7:0]);
            rd(IDX_RES_H, v);
            check(v, sum_exp[15:8]);
            rd(IDX_FLG, v);
            check(v, 8'h00);
            rd(IDX_WHI_L, v);
            rd(IDX_WHI_H, d);
            check({d, v}, hi);
        end
        $display("test window done");
        // dither: four samples step the delay from 0xf to 0x3
        wr(IDX_DLY, 8'h1f);
        conv(8'h21, 5'h1f, 5'h1f, dd);
        rd(IDX_DLY, v);
        check(v, 8'h13);
        // last open run is a one-tick gap followed by the sample
        t = 2 * (3 + int'(sl));
        check((open_len >= t - 2) && (open_len <= t + 2), 1);
        wr(IDX_DLY, 8'h00);
        // continuous: second result with no further command
        wr(IDX_CTRL, 8'h03);
        wr(IDX_CMD, 8'h01);
        wait_bit(IDX_FLG, 0, 1'b1);
        rd(IDX_RES_L, v);
        wait_bit(IDX_FLG, 0, 1'b1);
        wr(IDX_CTRL, 8'h01);
        wait_bit(IDX_CMD, 0, 1'b0);
        $display("test continuous done");
        // event start, halted in debug, then running in debug
        wr(IDX_SAMP, 8'h1f);
        // halt mid-sample: must still be busy long after it would end
        wr(IDX_CMD, 8'h01);
        dbg_halt_i <= 1'b1;
        repeat (200) @(posedge sys_clk_i);
        rd(IDX_CMD, v);
        check(v, 8'h01);
        dbg_halt_i <= 1'b0;
        wait_bit(IDX_CMD, 0, 1'b0);
        wr(IDX_EVT, 8'h01);
        dbg_halt_i <= 1'b1;
        pulse(0);
        rd(IDX_CMD, v);
        check(v, 8'h00);
        wr(IDX_DBG, 8'h01);
        pulse(0);
        rd(IDX_CMD, v);
        check(v, 8'h01);
        wait_bit(IDX_CMD, 0, 1'b0);
        dbg_halt_i <= 1'b0;
        wr(IDX_EVT, 8'h00);
        pulse(0);
        rd(IDX_CMD, v);
        check(v, 8'h00);
        $display("test events done");
        conclude();
    end
endmodule : adc_sequencer_control_tb_top
